// >>> timer16_capture_compare.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Counter runs from the external pin only when both clock select bits are 1.
// - External edge select bit picks rising or falling external edge to count.
// - External count edges are resynchronised to the processor clock before use.
// - Two 16-bit capture registers latch the counter on the selected pin edge.
// - Capture registers are read-only; writes leave them unchanged.
// - Channel 1 edge bit lives in control register 1, channel 2 in 2.
// - Capture sets its flag; interrupt when enabled and processor mask clear.
// - Capture flag clears after status read with flag set, then low byte access.
// - Reading capture high byte blocks captures and flag until low byte read.
// - Every valid capture overwrites the register with the latest counter value.
// - In one pulse or PWM mode only capture channel 2 captures.
// - Capture pins always reach capture logic, even when driven by software.
// - Both 16-bit compare registers are compared with the counter each timer tick.
// - Compare registers are software read/write, untouched by hardware, reset 8000h.
// - Match sets compare flag, drives programmed level, interrupts when enabled.
// - Compare pin latches are held low during reset.
// - Compare flag clears after status read with flag set, then low byte access.
// - Writing compare high byte suspends compare until its low byte is written.
// - With output enable clear, match drives no pin but still flags and interrupts.
// - Divide-by-2 matches at value; other clocks match at value plus 1.
// - Free-running counter resets to FFFCh; writing either low byte reloads FFFCh.
// - Rollover FFFFh to 0000h sets overflow flag; interrupts when enabled.

module timer16_capture_compare (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clkEn,
	input wire timer16_pkg::apb_req_t apbReq,
	output timer16_pkg::apb_rsp_t apbRsp,
	input wire logic [1:0] captureInputPin,
	input wire logic externalClockPin,
	input wire logic cpuIntMask,
	output logic [1:0] compareOutputPin,
	output logic [1:0] compareOutputOeN,
	output logic timerIrq
);
	import timer16_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] setByte(input logic [15:0] v, input logic hi, input logic [7:0] b);
		setByte = hi ? {b, v[7:0]} : {v[15:8], b};
	endfunction

	function automatic logic edgeSeen(input logic cur, input logic prev, input logic rising);
		edgeSeen = rising ? (cur & ~prev) : (~cur & prev);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] cr1_r, cr1_nxt, cr2_r, cr2_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [2:0] presc_r, presc_nxt;
	logic extS1_r, extS2_r, extS3_r;
	logic [1:0] capPrev_r;
	logic [15:0] icVal_r [2];
	logic [15:0] icVal_nxt [2];
	logic [15:0] ocVal_r [2];
	logic [15:0] ocVal_nxt [2];
	logic [1:0] icLock_r, icLock_nxt, ocSusp_r, ocSusp_nxt;
	logic [1:0] icf_r, icf_nxt, ocf_r, ocf_nxt;
	logic [1:0] icArm_r, icArm_nxt, ocArm_r, ocArm_nxt;
	logic tof_r, tof_nxt, tofArm_r, tofArm_nxt;
	logic [7:0] cntBuf_r, cntBuf_nxt;
	logic cntBufV_r, cntBufV_nxt;
	logic [1:0] cmpPin_r, cmpPin_nxt, cmpOeN_r, cmpOeN_nxt;
	logic irq_r, irq_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic access, wrEn, rdDone, mapped;
	logic [1:0] clkSel;
	logic [2:0] prescMask;
	logic tick, extEdge;
	logic [15:0] cntInc;
	logic [1:0] capEdge, capHit, cmpHit;
	logic pulseMode;
	logic [7:0] srView, rdByte;
	logic [7:0] wb;

	always_comb begin
		access = apbReq.psel & apbReq.penable & pready_r;
		wrEn = access & apbReq.pwrite;
		rdDone = access & ~apbReq.pwrite;
		wb = apbReq.pwdata[7:0];
		clkSel = {cr2_r[CR2_CC1], cr2_r[CR2_CC0]};
		pulseMode = cr2_r[CR2_OPM] | cr2_r[CR2_PWM];
		case (clkSel)
			CLK_DIV2: prescMask = MASK_DIV2;
			CLK_DIV4: prescMask = MASK_DIV4;
			CLK_DIV8: prescMask = MASK_DIV8;
			default: prescMask = MASK_DIV2;
		endcase
		// Edge taken from the resynchronised copies only
		extEdge = edgeSeen(extS2_r, extS3_r, cr2_r[CR2_EXTERNAL_EDGE_SELECT]);
		if (clkSel == CLK_EXT) begin
			tick = extEdge;
		end else begin
			tick = (presc_r & prescMask) == prescMask;
		end
		cntInc = cnt_r + 16'h0001;
		// Pins feed the edge detectors whatever their port direction
		capEdge[0] = edgeSeen(captureInputPin[0], capPrev_r[0], cr1_r[CR1_IEDG1]);
		capEdge[1] = edgeSeen(captureInputPin[1], capPrev_r[1], cr2_r[CR2_IEDG2]);
		capHit[0] = capEdge[0] & ~icLock_r[0] & ~pulseMode;
		capHit[1] = capEdge[1] & ~icLock_r[1];
		for (int i = 0; i < 2; i++) begin
			// Slow clocks see the match one count late
			if (clkSel == CLK_DIV2) begin
				cmpHit[i] = tick & ~ocSusp_r[i] & (cntInc == ocVal_r[i]);
			end else begin
				cmpHit[i] = tick & ~ocSusp_r[i] & (cnt_r == ocVal_r[i]);
			end
		end
		srView = 8'h00;
		srView[SR_ICF1] = icf_r[0];
		srView[SR_OCF1] = ocf_r[0];
		srView[SR_TOF] = tof_r;
		srView[SR_ICF2] = icf_r[1];
		srView[SR_OCF2] = ocf_r[1];
		mapped = 1'b1;
		case (apbReq.paddr)
			OFF_CR1: rdByte = cr1_r;
			OFF_CR2: rdByte = cr2_r;
			OFF_SR: rdByte = srView;
			OFF_IC1H: rdByte = icVal_r[0][15:8];
			OFF_IC1L: rdByte = icVal_r[0][7:0];
			OFF_IC2H: rdByte = icVal_r[1][15:8];
			OFF_IC2L: rdByte = icVal_r[1][7:0];
			OFF_OC1H: rdByte = ocVal_r[0][15:8];
			OFF_OC1L: rdByte = ocVal_r[0][7:0];
			OFF_OC2H: rdByte = ocVal_r[1][15:8];
			OFF_OC2L: rdByte = ocVal_r[1][7:0];
			OFF_CNTH: rdByte = cnt_r[15:8];
			OFF_ACNTH: rdByte = cnt_r[15:8];
			OFF_CNTL: rdByte = cntBufV_r ? cntBuf_r : cnt_r[7:0];
			OFF_ACNTL: rdByte = cntBufV_r ? cntBuf_r : cnt_r[7:0];
			default: begin
				rdByte = 8'h00;
				mapped = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// APB slave: one wait cycle, answer registered
	// ----------------------------------------
	always_comb begin
		pready_nxt = apbReq.psel & apbReq.penable & ~pready_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		if (pready_nxt) begin
			prdata_nxt = {24'h000000, apbReq.pwrite ? 8'h00 : rdByte};
			pslverr_nxt = ~mapped;
		end
	end

	// ----------------------------------------
	// Timer core
	// ----------------------------------------
	always_comb begin
		cr1_nxt = cr1_r;
		cr2_nxt = cr2_r;
		presc_nxt = presc_r + 3'h1;
		cnt_nxt = tick ? cntInc : cnt_r;
		icLock_nxt = icLock_r;
		ocSusp_nxt = ocSusp_r;
		icArm_nxt = icArm_r;
		ocArm_nxt = ocArm_r;
		tofArm_nxt = tofArm_r;
		icf_nxt = icf_r;
		ocf_nxt = ocf_r;
		tof_nxt = tof_r;
		cntBuf_nxt = cntBuf_r;
		cntBufV_nxt = cntBufV_r;
		cmpPin_nxt = cmpPin_r;
		for (int i = 0; i < 2; i++) begin
			icVal_nxt[i] = icVal_r[i];
			ocVal_nxt[i] = ocVal_r[i];
		end

		// Status read arms the capture flags that software saw, and any compare or overflow flag now set
		if (rdDone && apbReq.paddr == OFF_SR) begin
			icArm_nxt = icArm_r | {prdata_nxt[SR_ICF2], prdata_nxt[SR_ICF1]} & {icf_r[1], icf_r[0]};
			ocArm_nxt = ocArm_r | {ocf_r[1], ocf_r[0]};
			tofArm_nxt = tofArm_r | tof_r;
		end

		if (wrEn) begin
			case (apbReq.paddr)
				OFF_CR1: cr1_nxt = wb;
				OFF_CR2: cr2_nxt = wb;
				OFF_OC1H: begin
					ocVal_nxt[0] = setByte(ocVal_r[0], 1'b1, wb);
					ocSusp_nxt[0] = 1'b1;
				end
				OFF_OC1L: begin
					ocVal_nxt[0] = setByte(ocVal_r[0], 1'b0, wb);
					ocSusp_nxt[0] = 1'b0;
				end
				OFF_OC2H: begin
					ocVal_nxt[1] = setByte(ocVal_r[1], 1'b1, wb);
					ocSusp_nxt[1] = 1'b1;
				end
				OFF_OC2L: begin
					ocVal_nxt[1] = setByte(ocVal_r[1], 1'b0, wb);
					ocSusp_nxt[1] = 1'b0;
				end
				OFF_CNTL, OFF_ACNTL: begin
					cnt_nxt = CNT_RELOAD;
					presc_nxt = 3'h0;
				end
				default: ;
			endcase
		end

		// Capture high read locks the channel; the low read releases it
		if (rdDone) begin
			case (apbReq.paddr)
				OFF_IC1H: icLock_nxt[0] = 1'b1;
				OFF_IC1L: icLock_nxt[0] = 1'b0;
				OFF_IC2H: icLock_nxt[1] = 1'b1;
				OFF_IC2L: icLock_nxt[1] = 1'b0;
				OFF_CNTH, OFF_ACNTH: begin
					if (!cntBufV_r) begin
						cntBuf_nxt = cnt_r[7:0];
						cntBufV_nxt = 1'b1;
					end
				end
				OFF_CNTL, OFF_ACNTL: cntBufV_nxt = 1'b0;
				default: ;
			endcase
		end

		// Two-step clears; a same-cycle set below overrides them
		if (access && icArm_r[0] && apbReq.paddr == OFF_IC1L) begin
			icf_nxt[0] = 1'b0;
			icArm_nxt[0] = 1'b0;
		end
		if (access && icArm_r[1] && apbReq.paddr == OFF_IC2L) begin
			icf_nxt[1] = 1'b0;
			icArm_nxt[1] = 1'b0;
		end
		if (access && ocArm_r[0] && apbReq.paddr == OFF_OC1L) begin
			ocf_nxt[0] = 1'b0;
			ocArm_nxt[0] = 1'b0;
		end
		if (access && ocArm_r[1] && apbReq.paddr == OFF_OC2L) begin
			ocf_nxt[1] = 1'b0;
			ocArm_nxt[1] = 1'b0;
		end
		if (access && tofArm_r && apbReq.paddr == OFF_CNTL) begin
			tof_nxt = 1'b0;
			tofArm_nxt = 1'b0;
		end

		for (int i = 0; i < 2; i++) begin
			if (capHit[i]) begin
				icVal_nxt[i] = cnt_r;
				icf_nxt[i] = 1'b1;
			end
			if (cmpHit[i]) begin
				ocf_nxt[i] = 1'b1;
			end
		end
		if (cmpHit[0] && cr2_r[CR2_OC1E]) begin
			cmpPin_nxt[0] = cr1_r[CR1_OLVL1];
		end
		if (cmpHit[1] && cr2_r[CR2_OC2E]) begin
			cmpPin_nxt[1] = cr1_r[CR1_OLVL2];
		end
		if (tick && cnt_r == CNT_MAX) begin
			tof_nxt = 1'b1;
		end

		cmpOeN_nxt = ~{cr2_nxt[CR2_OC2E], cr2_nxt[CR2_OC1E]};
		// Pending flags keep requesting until enable and mask allow
		irq_nxt = ~cpuIntMask & ((cr1_r[CR1_CAPTURE_INTERRUPT_ENABLE] & (|icf_r)) | (cr1_r[CR1_COMPARE_INTERRUPT_ENABLE] & (|ocf_r))
			| (cr1_r[CR1_OVERFLOW_INTERRUPT_ENABLE] & tof_r));
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cr1_r <= CR_RESET;
			cr2_r <= CR_RESET;
			cnt_r <= CNT_RELOAD;
			presc_r <= 3'h0;
			extS1_r <= 1'b0;
			extS2_r <= 1'b0;
			extS3_r <= 1'b0;
			capPrev_r <= 2'h0;
			for (int i = 0; i < 2; i++) begin
				icVal_r[i] <= IC_RESET;
				ocVal_r[i] <= OC_RESET;
			end
			icLock_r <= 2'h0;
			ocSusp_r <= 2'h0;
			icf_r <= 2'h0;
			ocf_r <= 2'h0;
			icArm_r <= 2'h0;
			ocArm_r <= 2'h0;
			tof_r <= 1'b0;
			tofArm_r <= 1'b0;
			cntBuf_r <= 8'h00;
			cntBufV_r <= 1'b0;
			cmpPin_r <= 2'h0;
			cmpOeN_r <= 2'h3;
			irq_r <= 1'b0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else if (clkEn) begin
			cr1_r <= cr1_nxt;
			cr2_r <= cr2_nxt;
			cnt_r <= cnt_nxt;
			presc_r <= presc_nxt;
			extS1_r <= externalClockPin;
			extS2_r <= extS1_r;
			extS3_r <= extS2_r;
			capPrev_r <= captureInputPin;
			for (int i = 0; i < 2; i++) begin
				icVal_r[i] <= icVal_nxt[i];
				ocVal_r[i] <= ocVal_nxt[i];
			end
			icLock_r <= icLock_nxt;
			ocSusp_r <= ocSusp_nxt;
			icf_r <= icf_nxt;
			ocf_r <= ocf_nxt;
			icArm_r <= icArm_nxt;
			ocArm_r <= ocArm_nxt;
			tof_r <= tof_nxt;
			tofArm_r <= tofArm_nxt;
			cntBuf_r <= cntBuf_nxt;
			cntBufV_r <= cntBufV_nxt;
			cmpPin_r <= cmpPin_nxt;
			cmpOeN_r <= cmpOeN_nxt;
			irq_r <= irq_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb begin
		apbRsp.pready = pready_r;
		apbRsp.pslverr = pslverr_r;
		apbRsp.prdata = prdata_r;
		compareOutputPin = cmpPin_r;
		compareOutputOeN = cmpOeN_r;
		timerIrq = irq_r;
	end

endmodule
`default_nettype wire

// >>> timer16_pkg.sv
package timer16_pkg;

	// ----------------------------------------
	// APB carrier
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_t;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CR1 = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CR2 = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SR = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_IC1H = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_IC1L = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_OC1H = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_OC1L = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_CNTH = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_CNTL = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_ACNTH = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_ACNTL = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_IC2H = 8'h2C;
	localparam logic [ADDR_W-1:0] OFF_IC2L = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_OC2H = 8'h34;
	localparam logic [ADDR_W-1:0] OFF_OC2L = 8'h38;

	// ----------------------------------------
	// First control register fields
	// ----------------------------------------
	localparam int CR1_CAPTURE_INTERRUPT_ENABLE = 7;
	localparam int CR1_COMPARE_INTERRUPT_ENABLE = 6;
	localparam int CR1_OVERFLOW_INTERRUPT_ENABLE = 5;
	localparam int CR1_OLVL2 = 2;
	localparam int CR1_IEDG1 = 1;
	localparam int CR1_OLVL1 = 0;

	// ----------------------------------------
	// Second control register fields
	// ----------------------------------------
	localparam int CR2_OC1E = 7;
	localparam int CR2_OC2E = 6;
	localparam int CR2_OPM = 5;
	localparam int CR2_PWM = 4;
	localparam int CR2_CC1 = 3;
	localparam int CR2_CC0 = 2;
	localparam int CR2_IEDG2 = 1;
	localparam int CR2_EXTERNAL_EDGE_SELECT = 0;

	// ----------------------------------------
	// Status register fields
	// ----------------------------------------
	localparam int SR_ICF1 = 7;
	localparam int SR_OCF1 = 6;
	localparam int SR_TOF = 5;
	localparam int SR_ICF2 = 4;
	localparam int SR_OCF2 = 3;

	// ----------------------------------------
	// Clock select codes and reset values
	// ----------------------------------------
	localparam logic [1:0] CLK_DIV4 = 2'h0;
	localparam logic [1:0] CLK_DIV2 = 2'h1;
	localparam logic [1:0] CLK_DIV8 = 2'h2;
	localparam logic [1:0] CLK_EXT = 2'h3;
	localparam logic [2:0] MASK_DIV2 = 3'h1;
	localparam logic [2:0] MASK_DIV4 = 3'h3;
	localparam logic [2:0] MASK_DIV8 = 3'h7;

	localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] OC_RESET = 16'h8000;
	localparam logic [15:0] IC_RESET = 16'h0000;
	localparam logic [7:0] CR_RESET = 8'h00;

endpackage

// >>> timer16_capture_compare_props.sv
`timescale 1ns/1ns
`default_nettype none
module timer16_capture_compare_props
	import timer16_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clkEn,
	input wire timer16_pkg::apb_req_t apbReq,
	input wire timer16_pkg::apb_rsp_t apbRsp,
	input wire logic [1:0] captureInputPin,
	input wire logic externalClockPin,
	input wire logic cpuIntMask,
	input wire logic [1:0] compareOutputPin,
	input wire logic [1:0] compareOutputOeN,
	input wire logic timerIrq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic done;
	logic wrCr2;
	assign done = apbReq.psel && apbReq.penable && apbRsp.pready;
	assign wrCr2 = done && apbReq.pwrite && apbReq.paddr == OFF_CR2;

	chk_pin_reset: assert property ($past(srst) && $past(clkEn) |-> compareOutputPin == 2'h0 && !timerIrq)
		else $error("compare pins not low after reset");
	chk_oen_reset: assert property ($past(srst) && $past(clkEn) |-> compareOutputOeN == 2'h3)
		else $error("pin enables not off after reset");
	chk_oen_cause: assert property (!$past(srst) && !$stable(compareOutputOeN) |-> $past(wrCr2) || $past(wrCr2, 2))
		else $error("pin enable changed without control write");
	chk_irq_masked: assert property ($past(cpuIntMask) && $past(clkEn) |-> !timerIrq)
		else $error("interrupt raised while masked");
	chk_ready_pulse: assert property (apbRsp.pready && clkEn |=> !apbRsp.pready)
		else $error("ready longer than one cycle");
	chk_ready_time: assert property (apbReq.psel && !apbReq.penable && clkEn ##1 apbReq.penable && clkEn |=> apbRsp.pready)
		else $error("ready not one cycle after access");
	chk_err_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
		else $error("slave error without ready");
	chk_rdata_upper: assert property (apbRsp.pready |-> apbRsp.prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_unmapped_err: assert property (done && apbReq.paddr > OFF_OC2L |-> apbRsp.pslverr)
		else $error("unmapped access not refused");
	cover property (timerIrq && !cpuIntMask);
	cover property ($rose(compareOutputPin[0]));
	cover property (apbRsp.pslverr);
endmodule

bind timer16_capture_compare timer16_capture_compare_props uProps (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
	.apbReq(apbReq), .apbRsp(apbRsp), .captureInputPin(captureInputPin), .externalClockPin(externalClockPin),
	.cpuIntMask(cpuIntMask), .compareOutputPin(compareOutputPin), .compareOutputOeN(compareOutputOeN),
	.timerIrq(timerIrq));
`default_nettype wire

// >>> timer16_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
module timer16_pins_model (
	input wire logic sys_clk,
	input wire logic extRun,
	output logic [1:0] captureInputPin,
	output logic externalClockPin
);
	logic [3:0] divCnt;
	initial begin
		captureInputPin = 2'h0;
		externalClockPin = 1'b0;
		divCnt = 4'h0;
	end
	// Edge every 16 cycles, well past the minimum spacing
	always @(posedge sys_clk) begin
		divCnt <= divCnt + 4'h1;
		if (extRun && divCnt == 4'hF) externalClockPin <= !externalClockPin;
	end
	task automatic toggleCap(input int ch);
		@(posedge sys_clk);
		captureInputPin[ch] <= !captureInputPin[ch];
	endtask
endmodule
`default_nettype wire

// >>> test_timer16_capture_compare.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, got, exp) begin numChecks++; if ((got) !== (exp)) begin errors++; \
	$display("Error %s expected %h seen %h", nm, exp, got); end end
module test_timer16_capture_compare;
	import timer16_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic cpuIntMask = 1'b0;
	logic clkEn = 1'b1;
	logic extRun = 1'b0;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	logic [1:0] capPin;
	logic extPin;
	logic [1:0] cmpPin;
	logic [1:0] cmpOeN;
	logic irq;
	logic [7:0] rdData;
	logic slvErr;
	logic [15:0] v1;
	logic [15:0] v2;
	logic st;
	int errors = 0;
	int numChecks = 0;

	always #10 sys_clk = !sys_clk;

	timer16_capture_compare dut (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn), .apbReq(req), .apbRsp(rsp),
		.captureInputPin(capPin), .externalClockPin(extPin), .cpuIntMask(cpuIntMask),
		.compareOutputPin(cmpPin), .compareOutputOeN(cmpOeN), .timerIrq(irq));
	timer16_pins_model pm (.sys_clk(sys_clk), .extRun(extRun), .captureInputPin(capPin), .externalClockPin(extPin));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		req.psel <= 1'b1;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= {24'h0, wd};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		rdData = rsp.prdata[7:0];
		slvErr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (n >= 20) errors++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		`CHK("register", rdData, e)
	endtask
	task automatic rd16(input logic [7:0] hi, input logic [7:0] lo, output logic [15:0] v);
		apb(1'b0, hi, 8'h00);
		v[15:8] = rdData;
		apb(1'b0, lo, 8'h00);
		v[7:0] = rdData;
	endtask
	task automatic pollSr(input int b);
		int n;
		n = 0;
		do begin
			apb(1'b0, OFF_SR, 8'h00);
			n++;
		end while (rdData[b] !== 1'b1 && n < 100);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic tReset;
		`CHK("pins", cmpPin, 2'h0)
		`CHK("oen", cmpOeN, 2'h3)
		rdc(OFF_OC1H, 8'h80);
		rdc(OFF_OC1L, 8'h00);
		rdc(OFF_OC2H, 8'h80);
		wr(OFF_OC2L, 8'h5A);
		rdc(OFF_OC2L, 8'h5A);
		rdc(8'h3C, 8'h00);
		`CHK("slverr", slvErr, 1'b1)
		$display("reset test done");
	endtask
	task automatic tCapture;
		wr(OFF_CR1, 8'h82);
		cpuIntMask <= 1'b1;
		pm.toggleCap(0);
		repeat (3) @(posedge sys_clk);
		apb(1'b0, OFF_SR, 8'h00);
		`CHK("icf1", rdData[SR_ICF1], 1'b1)
		`CHK("irq masked", irq, 1'b0)
		cpuIntMask <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK("irq", irq, 1'b1)
		rd16(OFF_IC1H, OFF_IC1L, v1);
		repeat (2) @(posedge sys_clk);
		`CHK("irq clear", irq, 1'b0)
		apb(1'b0, OFF_IC1H, 8'h00);
		pm.toggleCap(0);
		pm.toggleCap(0);
		repeat (3) @(posedge sys_clk);
		apb(1'b0, OFF_SR, 8'h00);
		`CHK("icf1 locked", rdData[SR_ICF1], 1'b0)
		rdc(OFF_IC1L, v1[7:0]);
		wr(OFF_IC1H, 8'h55);
		wr(OFF_IC1L, 8'h55);
		rd16(OFF_IC1H, OFF_IC1L, v2);
		`CHK("ic1 kept", v2, v1)
		pm.toggleCap(0);
		pm.toggleCap(0);
		repeat (3) @(posedge sys_clk);
		apb(1'b0, OFF_SR, 8'h00);
		`CHK("icf1 again", rdData[SR_ICF1], 1'b1)
		rd16(OFF_IC1H, OFF_IC1L, v2);
		`CHK("ic1 new", v2 !== v1, 1'b1)
		$display("capture test done");
	endtask
	task automatic tCap2;
		wr(OFF_CR2, 8'h10);
		pm.toggleCap(0);
		pm.toggleCap(0);
		pm.toggleCap(1);
		repeat (3) @(posedge sys_clk);
		apb(1'b0, OFF_SR, 8'h00);
		`CHK("icf1 pwm", rdData[SR_ICF1], 1'b0)
		`CHK("icf2 rise", rdData[SR_ICF2], 1'b0)
		pm.toggleCap(1);
		repeat (3) @(posedge sys_clk);
		apb(1'b0, OFF_SR, 8'h00);
		`CHK("icf2 fall", rdData[SR_ICF2], 1'b1)
		apb(1'b0, OFF_IC2L, 8'h00);
		$display("capture two test done");
	endtask
	task automatic tCompare;
		wr(OFF_CR1, 8'h45);
		wr(OFF_CR2, 8'h84);
		wr(OFF_OC1H, 8'h00);
		wr(OFF_OC1L, 8'h10);
		wr(OFF_OC2H, 8'h00);
		wr(OFF_CNTL, 8'h00);
		pollSr(SR_OCF1);
		`CHK("pin1", cmpPin[0], 1'b1)
		`CHK("oen", cmpOeN, 2'h2)
		`CHK("irq", irq, 1'b1)
		// Counter passes the suspended value meanwhile
		repeat (200) @(posedge sys_clk);
		apb(1'b0, OFF_SR, 8'h00);
		`CHK("ocf2 held", rdData[SR_OCF2], 1'b0)
		`CHK("tof", rdData[SR_TOF], 1'b1)
		wr(OFF_OC1L, 8'h10);
		apb(1'b0, OFF_SR, 8'h00);
		`CHK("ocf1 clear", rdData[SR_OCF1], 1'b0)
		wr(OFF_OC2L, 8'hC0);
		pollSr(SR_OCF2);
		`CHK("ocf2", rdData[SR_OCF2], 1'b1)
		`CHK("pin2 idle", cmpPin[1], 1'b0)
		$display("compare test done");
	endtask
	// Divide-by-8: ticks land 8 cycles apart after the reload, so the flag must wait for value plus 1
	task automatic tSlowCmp;
		wr(OFF_CR1, 8'h40);
		wr(OFF_CR2, 8'h88);
		wr(OFF_OC1H, 8'h00);
		wr(OFF_OC1L, 8'h02);
		wr(OFF_CNTL, 8'h00);
		repeat (50) @(posedge sys_clk);
		apb(1'b0, OFF_SR, 8'h00);
		`CHK("ocf1 at value", rdData[SR_OCF1], 1'b0)
		`CHK("pin1 at value", cmpPin[0], 1'b1)
		repeat (4) @(posedge sys_clk);
		apb(1'b0, OFF_SR, 8'h00);
		`CHK("ocf1 at value plus one", rdData[SR_OCF1], 1'b1)
		`CHK("pin1 at value plus one", cmpPin[0], 1'b0)
		$display("slow compare test done");
	endtask
	task automatic tExt;
		for (int e = 0; e < 2; e++) begin
			wr(OFF_CR2, e ? 8'h0D : 8'h0C);
			wr(OFF_CNTL, 8'h00);
			st = extPin;
			extRun <= 1'b1;
			repeat (336) @(posedge sys_clk);
			extRun <= 1'b0;
			repeat (20) @(posedge sys_clk);
			rd16(OFF_CNTH, OFF_CNTL, v1);
			`CHK("ext count", v1, CNT_RELOAD + ((e[0] == st) ? 16'h000A : 16'h000B))
		end
		$display("external clock test done");
	endtask
	// A frozen block must not count, so the read sees only one count past the reload value
	task automatic tFreeze;
		wr(OFF_CR2, 8'h04);
		wr(OFF_CNTL, 8'h00);
		clkEn <= 1'b0;
		repeat (40) @(posedge sys_clk);
		clkEn <= 1'b1;
		rd16(OFF_CNTH, OFF_CNTL, v1);
		`CHK("frozen count", v1, CNT_RELOAD + 16'h0001)
		$display("clock enable test done");
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", numChecks, errors);
		if (errors == 0 && numChecks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		end_sim;
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		tReset;
		tCapture;
		tCap2;
		tCompare;
		tSlowCmp;
		tExt;
		tFreeze;
		end_sim;
	end
endmodule
`default_nettype wire
